// ==== src/ftm_pkg.sv ====
// Constants, state and carrier types for the fan and temperature monitor pin logic.
// Assumes a single 100 MHz clock and inputs already synchronous to it.
// Function
// - Six active-low open-drain general lines; they only pull low, otherwise float.
// - After power-on reset, general line 0 takes its state from the strap input.
// - Two fan-drive outputs, each with its own duty setting; one shared configuration bit sets the polarity of both.
// - One logic-level tachometer input per fan channel senses fan speed.
// - Fan-failure output pulls low whenever either fan is detected as failed.
// - Overheat alarm output is active-low and open-drain.
// - Reference output enabled only while measuring, high impedance in between.
// - Bus slave address comes from the two address-select pins.
// - Write byte, read byte, send byte, receive byte; receive returns last selected register.
// - Reading overheat status clears flag and alarm; flag reasserts next conversion if still hot.
package ftm_pkg;
   // Bus address base; the two select pins fill the low bits
   localparam logic [6:0] FTM_ADDR_BASE   = 7'h18;

   // Register offsets
   localparam logic [7:0] REG_TEMP_A      = 8'h00;
   localparam logic [7:0] REG_TEMP_B      = 8'h01;
   localparam logic [7:0] REG_CONFIG      = 8'h02;
   localparam logic [7:0] REG_OT_MASK     = 8'h03;
   localparam logic [7:0] REG_OT_STATUS   = 8'h04;
   localparam logic [7:0] REG_DUTY_A      = 8'h05;
   localparam logic [7:0] REG_DUTY_B      = 8'h06;
   localparam logic [7:0] REG_OT_LIMIT_A  = 8'h07;
   localparam logic [7:0] REG_OT_LIMIT_B  = 8'h08;
   localparam logic [7:0] REG_GPIO        = 8'h09;
   localparam logic [7:0] REG_FAN_STATUS  = 8'h0a;

   // Field positions
   localparam int         CFG_INVERT_BIT  = 4;

   // Values after reset
   localparam logic [7:0] CONFIG_RESET    = 8'h10;
   localparam logic [7:0] OT_MASK_RESET   = 8'h00;
   localparam logic [7:0] DUTY_RESET      = 8'h00;
   localparam logic [7:0] OT_LIMIT_RESET  = 8'h50;
   localparam logic [7:0] GPIO_RESET      = 8'hff;

   // Timing
   localparam int         CLK_PERIOD_NS   = 10;
   localparam int         CONV_TIME_MS    = 250;
   localparam int         IDLE_TIME_MS    = 250;
   localparam int         TACH_TIME_MS    = 1000;
   localparam int         CONV_CYCLES     = CONV_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int         IDLE_CYCLES     = IDLE_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int         TACH_CYCLES     = TACH_TIME_MS * 1000000 / CLK_PERIOD_NS;

   typedef enum {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
      ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK, ST_WAIT_STOP
   } ftm_state_type;

   // Per fan channel settings and last sample
   typedef struct packed {
      logic [7:0] duty;
      logic [7:0] otLimit;
      logic [7:0] temp;
   } ftm_chan_type;
endpackage

// ==== src/ftm_pins.sv ====
// Pin logic of the fan and temperature monitor: bus slave, fan drive, tach, alarms, general lines.
// Assumes bus and pin inputs synchronous to clk; open-drain wires are resolved outside.
`timescale 1ns/1ns
module ftm_pins
   import ftm_pkg::*;
#(
   parameter int NUM_GPIO = 6,
   parameter int CONV_CYC = CONV_CYCLES,
   parameter int IDLE_CYC = IDLE_CYCLES,
   parameter int TACH_CYC = TACH_CYCLES
) (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                smbClkIn,
   input  wire logic                smbDataIn,
   output      logic                smbDataOut,
   output      logic                smbDataOe,
   input  wire logic                addrSelectLo,
   input  wire logic                addrSelectHi,
   input  wire logic [7:0]          thermistorInA,
   input  wire logic [7:0]          thermistorInB,
   input  wire logic                fanSpeedInA,
   input  wire logic                fanSpeedInB,
   output      logic                fanDriveOutA,
   output      logic                fanDriveOutAOe,
   output      logic                fanDriveOutB,
   output      logic                fanDriveOutBOe,
   output      logic                fanFailNOut,
   output      logic                fanFailNOe,
   output      logic                overheatAlarmNOut,
   output      logic                overheatAlarmNOe,
   output      logic                refDriveOe,
   input  wire logic [NUM_GPIO-1:0] generalIoLinesIn,
   output      logic [NUM_GPIO-1:0] generalIoLinesOut,
   output      logic [NUM_GPIO-1:0] generalIoLinesOe,
   input  wire logic                gpioPresetIn
);
   localparam int PERIOD = CONV_CYC + IDLE_CYC;
   localparam int CNT_W  = $clog2(PERIOD + 1);
   localparam int TACH_W = $clog2(TACH_CYC + 1);

   ftm_state_type     state;
   ftm_chan_type      chan [2];
   logic [6:0]        slaveAddr;
   logic              sclQ;
   logic              sdaQ;
   logic              sclRise;
   logic              sclFall;
   logic              startCond;
   logic              stopCond;
   logic [7:0]        shiftReg;
   logic [7:0]        txShift;
   logic [3:0]        bitCnt;
   logic [7:0]        pointer;
   logic [7:0]        rdData;
   logic              loadRead;
   logic              regWrite;
   logic              readClr;
   logic [7:0]        cfgReg;
   logic [7:0]        otMask;
   logic [7:0]        gpioOut;
   logic [1:0]        otStatus;
   logic [1:0]        failed;
   logic [1:0]        tach;
   logic [1:0]        driveOe;
   logic [7:0]        tempIn [2];
   logic [7:0]        pwmCnt;
   logic [CNT_W-1:0]  phaseCnt;
   logic              convDone;
   logic              strapDone;

   assign slaveAddr = {FTM_ADDR_BASE[6:2], addrSelectHi, addrSelectLo};
   assign sclRise   = smbClkIn & ~sclQ;
   assign sclFall   = ~smbClkIn & sclQ;
   assign startCond = smbClkIn & sclQ & sdaQ & ~smbDataIn;
   assign stopCond  = smbClkIn & sclQ & ~sdaQ & smbDataIn;
   assign loadRead  = sclFall && ((state == ST_ADDR_ACK && shiftReg[0]) || state == ST_RACK);
   assign regWrite  = sclFall && state == ST_WDATA && bitCnt == 4'h8;
   assign readClr   = loadRead && pointer == REG_OT_STATUS;
   assign tach      = {fanSpeedInB, fanSpeedInA};
   assign tempIn[0] = thermistorInA;
   assign tempIn[1] = thermistorInB;
   assign convDone  = phaseCnt == CNT_W'(CONV_CYC - 1);

   // Open-drain pins only ever pull low
   assign smbDataOut        = 1'b0;
   assign fanDriveOutA      = 1'b0;
   assign fanDriveOutB      = 1'b0;
   assign fanFailNOut       = 1'b0;
   assign overheatAlarmNOut = 1'b0;
   assign generalIoLinesOut = '0;
   assign fanDriveOutAOe    = driveOe[0];
   assign fanDriveOutBOe    = driveOe[1];

   // Bus line sampling for edge and start/stop detection
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclQ <= 1'b1;
         sdaQ <= 1'b1;
      end else begin
         sclQ <= smbClkIn;
         sdaQ <= smbDataIn;
      end
   end

   // Read data selection
   always_comb begin
      unique case (pointer)
         REG_TEMP_A:     rdData = chan[0].temp;
         REG_TEMP_B:     rdData = chan[1].temp;
         REG_CONFIG:     rdData = cfgReg;
         REG_OT_MASK:    rdData = otMask;
         REG_OT_STATUS:  rdData = {6'h00, otStatus};
         REG_DUTY_A:     rdData = chan[0].duty;
         REG_DUTY_B:     rdData = chan[1].duty;
         REG_OT_LIMIT_A: rdData = chan[0].otLimit;
         REG_OT_LIMIT_B: rdData = chan[1].otLimit;
         REG_GPIO:       rdData = 8'(generalIoLinesIn);
         REG_FAN_STATUS: rdData = {6'h00, failed};
         default:        rdData = 8'h00;
      endcase
   end

   // Bus slave: byte transactions, the pointer persists for receive byte
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state     <= ST_IDLE;
         shiftReg  <= 8'h00;
         txShift   <= 8'h00;
         bitCnt    <= 4'h0;
         pointer   <= 8'h00;
         smbDataOe <= 1'b0;
      end else if (startCond) begin
         state     <= ST_ADDR;
         bitCnt    <= 4'h0;
         smbDataOe <= 1'b0;
      end else if (stopCond) begin
         state     <= ST_IDLE;
         smbDataOe <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE, ST_WAIT_STOP: begin
            end
            ST_ADDR, ST_CMD, ST_WDATA: begin
               if (sclRise) begin
                  shiftReg <= {shiftReg[6:0], smbDataIn};
                  bitCnt   <= bitCnt + 4'h1;
               end
               if (sclFall && bitCnt == 4'h8) begin
                  bitCnt <= 4'h0;
                  if (state == ST_ADDR) begin
                     if (shiftReg[7:1] == slaveAddr) begin
                        smbDataOe <= 1'b1;
                        state     <= ST_ADDR_ACK;
                     end else begin
                        state <= ST_WAIT_STOP;
                     end
                  end else if (state == ST_CMD) begin
                     pointer   <= shiftReg;
                     smbDataOe <= 1'b1;
                     state     <= ST_CMD_ACK;
                  end else begin
                     smbDataOe <= 1'b1;
                     state     <= ST_WDATA_ACK;
                  end
               end
            end
            ST_ADDR_ACK, ST_RACK: begin
               if (state == ST_RACK && sclRise && smbDataIn) begin
                  state <= ST_WAIT_STOP;
               end else if (loadRead) begin
                  txShift   <= {rdData[6:0], 1'b0};
                  smbDataOe <= ~rdData[7];
                  bitCnt    <= 4'h0;
                  state     <= ST_RDATA;
               end else if (sclFall) begin
                  smbDataOe <= 1'b0;
                  state     <= ST_CMD;
               end
            end
            ST_CMD_ACK, ST_WDATA_ACK: begin
               if (sclFall) begin
                  smbDataOe <= 1'b0;
                  state     <= (state == ST_CMD_ACK) ? ST_WDATA : ST_WAIT_STOP;
               end
            end
            ST_RDATA: begin
               if (sclFall) begin
                  if (bitCnt == 4'h7) begin
                     smbDataOe <= 1'b0;
                     state     <= ST_RACK;
                  end else begin
                     smbDataOe <= ~txShift[7];
                     txShift   <= {txShift[6:0], 1'b0};
                     bitCnt    <= bitCnt + 4'h1;
                  end
               end
            end
         endcase
      end
   end

   // Settings written over the bus and samples taken at conversion end; strap caught on the first edge after reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfgReg    <= CONFIG_RESET;
         otMask    <= OT_MASK_RESET;
         gpioOut   <= GPIO_RESET;
         strapDone <= 1'b0;
         for (int i = 0; i < 2; i++) begin
            chan[i].duty    <= DUTY_RESET;
            chan[i].otLimit <= OT_LIMIT_RESET;
            chan[i].temp    <= 8'h00;
         end
      end else begin
         strapDone <= 1'b1;
         for (int i = 0; i < 2; i++) begin
            if (convDone) begin
               chan[i].temp <= tempIn[i];
            end
         end
         if (!strapDone) begin
            gpioOut[0] <= gpioPresetIn;
         end else if (regWrite) begin
            unique case (pointer)
               REG_CONFIG:     cfgReg          <= shiftReg;
               REG_OT_MASK:    otMask          <= shiftReg;
               REG_DUTY_A:     chan[0].duty    <= shiftReg;
               REG_DUTY_B:     chan[1].duty    <= shiftReg;
               REG_OT_LIMIT_A: chan[0].otLimit <= shiftReg;
               REG_OT_LIMIT_B: chan[1].otLimit <= shiftReg;
               REG_GPIO:       gpioOut         <= shiftReg;
               default: begin
               end
            endcase
         end
      end
   end

   // General lines: released until the strap has been taken
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         generalIoLinesOe <= '0;
      end else begin
         generalIoLinesOe <= strapDone ? ~gpioOut[NUM_GPIO-1:0] : '0;
      end
   end

   // Measurement phase; reference driven only during conversion
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phaseCnt   <= CNT_W'(PERIOD - 1);
         refDriveOe <= 1'b0;
      end else begin
         phaseCnt <= (phaseCnt == CNT_W'(PERIOD - 1)) ? '0 : phaseCnt + 1'b1;
         if (phaseCnt == CNT_W'(PERIOD - 1)) begin
            refDriveOe <= 1'b1;
         end else if (convDone) begin
            refDriveOe <= 1'b0;
         end
      end
   end

   // Shared PWM period counter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pwmCnt <= 8'h00;
      end else begin
         pwmCnt <= pwmCnt + 8'h01;
      end
   end

   // Per channel: fan drive, tach watchdog and overheat flag
   for (genvar c = 0; c < 2; c++) begin : g_chan
      logic              tachQ;
      logic [TACH_W-1:0] tachTimer;
      logic              driveOn;

      assign driveOn = chan[c].duty > pwmCnt;

      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            driveOe[c] <= 1'b0;
         end else begin
            driveOe[c] <= cfgReg[CFG_INVERT_BIT] ? ~driveOn : driveOn;
         end
      end

      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            tachQ     <= 1'b0;
            tachTimer <= '0;
            failed[c] <= 1'b0;
         end else begin
            tachQ <= tach[c];
            if (tach[c] && !tachQ) begin
               tachTimer <= '0;
               failed[c] <= 1'b0;
            end else if (chan[c].duty == 8'h00) begin
               tachTimer <= '0;
               failed[c] <= 1'b0;
            end else if (tachTimer == TACH_W'(TACH_CYC - 1)) begin
               failed[c] <= 1'b1;
            end else begin
               tachTimer <= tachTimer + 1'b1;
            end
         end
      end

      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            otStatus[c] <= 1'b0;
         end else begin
            if (convDone && tempIn[c] > chan[c].otLimit) begin
               otStatus[c] <= 1'b1;
            end else if (readClr) begin
               otStatus[c] <= 1'b0;
            end
         end
      end
   end

   // Alarm outputs, registered
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fanFailNOe       <= 1'b0;
         overheatAlarmNOe <= 1'b0;
      end else begin
         fanFailNOe       <= |failed;
         overheatAlarmNOe <= |(otStatus & ~otMask[1:0]);
      end
   end

   AST_GPIO_OD: assert property (@(posedge clk) disable iff (rst) generalIoLinesOut == '0)
      else $error("general line drives high");
   AST_STRAP: assert property (@(posedge clk) disable iff (rst)
      $rose(strapDone) |=> generalIoLinesOe[0] == !$past(gpioPresetIn, 2))
      else $error("line 0 does not follow strap");
   AST_PWM_OFF: assert property (@(posedge clk) disable iff (rst)
      (chan[0].duty == 8'h00 && cfgReg[CFG_INVERT_BIT]) [*2] |-> fanDriveOutAOe)
      else $error("fan drive not held off at zero duty");
   AST_TACH: assert property (@(posedge clk) disable iff (rst) $rose(fanSpeedInA) |=> !failed[0])
      else $error("tach pulse did not clear failure");
   AST_FANFAIL: assert property (@(posedge clk) disable iff (rst) failed != 2'b00 |=> fanFailNOe)
      else $error("fan failure not signalled");
   AST_OT: assert property (@(posedge clk) disable iff (rst)
      (otStatus & ~otMask[1:0]) == 2'b00 |=> !overheatAlarmNOe)
      else $error("alarm without unmasked fault");
   AST_REF: assert property (@(posedge clk) disable iff (rst)
      convDone |=> !refDriveOe ##1 (!refDriveOe && phaseCnt == CNT_W'(CONV_CYC + 1)))
      else $error("reference driven between measurements");
   AST_ADDR_ACK: assert property (@(posedge clk) disable iff (rst)
      $rose(state == ST_ADDR_ACK) |-> smbDataOe && shiftReg[7:1] == slaveAddr)
      else $error("acknowledged a foreign address");
   AST_RX_BIT: assert property (@(posedge clk) disable iff (rst)
      loadRead && !startCond |=> smbDataOe == ~$past(rdData[7]))
      else $error("first read bit wrong");
   AST_OT_CLEAR: assert property (@(posedge clk) disable iff (rst)
      readClr && !convDone |=> otStatus == 2'b00 ##1 !overheatAlarmNOe)
      else $error("status read did not clear");
   AST_RELEASE: assert property (@(posedge clk) disable iff (rst)
      !strapDone |-> generalIoLinesOe == '0 && !fanFailNOe && !overheatAlarmNOe)
      else $error("open-drain driven before evaluation");
endmodule

// ==== verification/ftm_smb_host.sv ====
// SMBus host model: start, stop and byte transfers as bus master.
// Assumes the device enable pulls data low; a pull-up lifts a released line.
`timescale 1ns/1ns
module ftm_smb_host (
   input  wire logic clk,
   input  wire logic devLow,
   output      logic scl,
   output      logic sda
);
   logic hostLow = 1'b0;
   // Wired-and line with pull-up
   assign sda = ~(hostLow | devLow);
   initial scl = 1'b1;
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Start, or repeated start from a low clock
   task automatic start();
      hostLow = 1'b0;
      tk(2);
      scl = 1'b1;
      tk(4);
      hostLow = 1'b1;
      tk(4);
      scl = 1'b0;
      tk(2);
   endtask
   task automatic stop();
      hostLow = 1'b1;
      tk(2);
      scl = 1'b1;
      tk(4);
      hostLow = 1'b0;
      tk(4);
   endtask
   // Data set while clock is low, sampled while high
   task automatic bitx(input logic b, output logic r);
      hostLow = ~b;
      tk(2);
      scl = 1'b1;
      tk(4);
      r = sda;
      scl = 1'b0;
      tk(2);
   endtask
   task automatic sendb(input logic [7:0] d, inout logic ok);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(d[i], r);
      bitx(1'b1, r);
      ok = ok & ~r;
   endtask
   task automatic recvb(output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitx(1'b1, r);
         d[i] = r;
      end
      bitx(1'b1, r);
   endtask
   // Write byte, or send byte when hasData is low
   task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, input logic hasData,
                     output logic ok);
      ok = 1'b1;
      start();
      sendb({a, 1'b0}, ok);
      sendb(c, ok);
      if (hasData) sendb(d, ok);
      stop();
   endtask
   // Read byte, or receive byte when hasCmd is low
   task automatic rd(input logic [6:0] a, input logic [7:0] c, input logic hasCmd, output logic [7:0] d);
      logic ok;
      ok = 1'b1;
      if (hasCmd) begin
         start();
         sendb({a, 1'b0}, ok);
         sendb(c, ok);
      end
      start();
      sendb({a, 1'b1}, ok);
      recvb(d);
      stop();
   endtask
endmodule

// ==== verification/tb_fan_temp_monitor_pins.sv ====
// Testbench of the fan and temperature monitor pin logic with an SMBus host model.
// Assumes pull-ups on all open-drain lines and shortened measurement counts.
`timescale 1ns/1ns
module tb_fan_temp_monitor_pins;
   import ftm_pkg::*;
   localparam logic [6:0] ADDR = FTM_ADDR_BASE | 7'h02;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       fanB = 1'b0;
   logic       strapLvl = 1'b0;
   logic [1:0] addrSel = 2'h2;
   logic       scl, sda, fanA, tachRun, smbOut, smbOe, ok;
   logic       dAo, dAe, dBo, dBe, failO, failE, otO, otE, refE;
   logic [7:0] thA, thB, d;
   logic [5:0] gpOut, gpOe;
   logic [3:0] tcnt = 4'h0;
   int         bad_count = 0;
   int         cmp_count = 0;
   always #5 clk = ~clk;
   always @(posedge clk) begin
      tcnt <= tcnt + 4'h1;
      fanB <= #1 tachRun & tcnt[3];
   end
   ftm_smb_host u_host (.clk(clk), .devLow(smbOe), .scl(scl), .sda(sda));
   ftm_pins #(.CONV_CYC(20), .IDLE_CYC(20), .TACH_CYC(50)) u_dut (
      .clk(clk), .rst(rst), .smbClkIn(scl), .smbDataIn(sda), .smbDataOut(smbOut), .smbDataOe(smbOe),
      .addrSelectLo(addrSel[0]), .addrSelectHi(addrSel[1]), .thermistorInA(thA), .thermistorInB(thB),
      .fanSpeedInA(fanA), .fanSpeedInB(fanB), .fanDriveOutA(dAo), .fanDriveOutAOe(dAe),
      .fanDriveOutB(dBo), .fanDriveOutBOe(dBe), .fanFailNOut(failO), .fanFailNOe(failE),
      .overheatAlarmNOut(otO), .overheatAlarmNOe(otE), .refDriveOe(refE), .generalIoLinesIn(~gpOe),
      .generalIoLinesOut(gpOut), .generalIoLinesOe(gpOe), .gpioPresetIn(strapLvl));
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      if (bad_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic tmo(input int i, input int n);
      if (i >= n) begin
         bad_count++;
         close_out();
      end
   endtask
   task automatic w(input logic [7:0] c, input logic [7:0] v);
      u_host.wr(ADDR, c, v, 1'b1, ok);
      chk(16'(ok), 16'h0001);
   endtask
   task automatic t_reset(input logic p);
      rst = 1'b1;
      strapLvl = p;
      tk(2);
      chk({smbOe, dAe, dBe, failE, otE, refE, gpOe}, 16'h0000);
      tk(2);
      rst = 1'b0;
      tk(3);
      chk(16'(gpOe), {15'h0000, ~p});
      chk({dAe, dBe, refE}, 16'h0007);
      chk({smbOut, dAo, dBo, failO, otO, gpOut}, 16'h0000);
      u_host.rd(ADDR, REG_OT_MASK, 1'b1, d);
      chk(16'(d), 16'(OT_MASK_RESET));
   endtask
   task automatic t_addr();
      for (int s = 1; s < 3; s++) begin
         addrSel = 2'(s);
         for (int a = 0; a < 4; a++) begin
            u_host.wr(FTM_ADDR_BASE | 7'(a), REG_DUTY_B, 8'h00, 1'b1, ok);
            chk(16'(ok), 16'(a == s));
         end
      end
   endtask
   task automatic t_regs();
      w(REG_DUTY_A, 8'h80);
      u_host.rd(ADDR, REG_DUTY_A, 1'b1, d);
      chk(16'(d), 16'h0080);
      u_host.rd(ADDR, 8'h20, 1'b1, d);
      chk(16'(d), 16'h0000);
      u_host.wr(ADDR, REG_OT_LIMIT_A, 8'h00, 1'b0, ok);
      u_host.rd(ADDR, 8'h00, 1'b0, d);
      chk(16'(d), 16'h0050);
      w(REG_GPIO, 8'h3c);
      chk(16'(gpOe), 16'h0003);
      u_host.rd(ADDR, REG_GPIO, 1'b1, d);
      chk(16'(d[5:0]), 16'h003c);
   endtask
   task automatic t_pwm();
      int a;
      int b;
      w(REG_DUTY_A, 8'hff);
      w(REG_DUTY_B, 8'h40);
      for (int k = 0; k < 2; k++) begin
         a = 0;
         b = 0;
         repeat (256) begin
            tk(1);
            a += int'(dAe);
            b += int'(dBe);
         end
         chk(16'(a), (k == 1) ? 16'h00ff : 16'h0001);
         chk(16'(b), (k == 1) ? 16'h0040 : 16'h00c0);
         w(REG_CONFIG, (k == 1) ? CONFIG_RESET : 8'h00);
      end
   endtask
   task automatic t_tach();
      int i;
      fanA = 1'b1;
      tk(2);
      fanA = 1'b0;
      for (i = 0; i < 5 && failE !== 1'b0; i++) tk(1);
      tmo(i, 5);
      chk(16'(failE), 16'h0000);
      tk(40);
      chk(16'(failE), 16'h0000);
      for (i = 0; i < 30 && failE !== 1'b1; i++) tk(1);
      tmo(i, 30);
      chk(16'(failE), 16'h0001);
   endtask
   task automatic t_ref();
      int n;
      n = 0;
      repeat (80) begin
         tk(1);
         n += int'(refE);
      end
      chk(16'(n), 16'h0028);
   endtask
   task automatic t_ot();
      int i;
      thA = 8'h60;
      for (i = 0; i < 100 && otE !== 1'b1; i++) tk(1);
      tmo(i, 100);
      thA = 8'h10;
      tk(45);
      chk(16'(otE), 16'h0001);
      u_host.rd(ADDR, REG_OT_STATUS, 1'b1, d);
      chk(16'(d), 16'h0001);
      tk(3);
      chk(16'(otE), 16'h0000);
      u_host.rd(ADDR, REG_OT_STATUS, 1'b1, d);
      chk(16'(d), 16'h0000);
      u_host.rd(ADDR, REG_TEMP_A, 1'b1, d);
      chk(16'(d), 16'h0010);
      thA = 8'h60;
      for (i = 0; i < 100 && otE !== 1'b1; i++) tk(1);
      tmo(i, 100);
      chk(16'(otE), 16'h0001);
      w(REG_OT_MASK, 8'h01);
      tk(3);
      chk(16'(otE), 16'h0000);
   endtask
   initial begin
      thA = 8'h00;
      thB = 8'h22;
      fanA = 1'b0;
      tachRun = 1'b1;
      t_reset(1'b0);
      t_addr();
      t_regs();
      t_pwm();
      t_tach();
      t_ref();
      t_ot();
      t_reset(1'b1);
      close_out();
   end
endmodule
